// ===== inc/obc_pkg.sv
// constants, types and decode helpers of the option byte configuration block
//
// Notes on behaviour
// - debug tool writes every option byte in-circuit
// - firmware writes apply live, except protection bytes
// - protection byte 0xAA disables readout protection
// - area size 0 none, 1 vectors only
// - size 2: pages 0-1, read/write protected
// - size 3+: pages 0..n-1 write protected
// - independent dog bit set: hardware activation
// - independent dog halt bit set: stops in halt
// - window dog bit set: hardware activation
// - window dog halt bit: clear stops, set resets
// - fast oscillator wait 1/16/512/4096 cycles
// - slow oscillator wait 1/16/512/4096 cycles
`default_nettype none
package obc_pkg;

	// ****************************************************************
	// option byte locations in the data memory space
	// ****************************************************************
	localparam logic [15:0] OBC_ADDR_READOUT = 16'h4800;
	localparam logic [15:0] OBC_ADDR_BOOT = 16'h4802;
	localparam logic [15:0] OBC_ADDR_RSVD = 16'h4807;
	localparam logic [15:0] OBC_ADDR_DOG = 16'h4808;
	localparam logic [15:0] OBC_ADDR_OSC = 16'h4809;
	localparam logic [15:0] OBC_ADDR_BROWN = 16'h480A;
	localparam logic [15:0] OBC_ADDR_LDR_HI = 16'h480B;
	localparam logic [15:0] OBC_ADDR_LDR_LO = 16'h480C;

	// ****************************************************************
	// factory settings
	// ****************************************************************
	localparam logic [7:0] OBC_RST_READOUT = 8'hAA;
	localparam logic [7:0] OBC_RST_BOOT = 8'h00;
	localparam logic [7:0] OBC_RST_DOG = 8'h00;
	localparam logic [7:0] OBC_RST_OSC = 8'h00;
	localparam logic [7:0] OBC_RST_BROWN = 8'h00;
	localparam logic [7:0] OBC_RST_LDR = 8'h00;
	localparam logic [7:0] OBC_RSVD_READ = 8'h00;

	// ****************************************************************
	// field layout
	// ****************************************************************
	localparam logic [7:0] OBC_READOUT_OFF = 8'hAA; // protection disabled
	localparam logic [7:0] OBC_BOOT_NONE = 8'h00;
	localparam logic [7:0] OBC_BOOT_VECT = 8'h01;
	localparam logic [7:0] OBC_BOOT_RWPROT = 8'h02;
	localparam logic [7:0] OBC_BOOT_STEP = 8'h01; // last page = size - 1
	localparam logic [7:0] OBC_LOW4_MASK = 8'h0F; // upper nibble reserved
	localparam int OBC_BIT_IDOG_HW = 0;
	localparam int OBC_BIT_IDOG_HALT = 1;
	localparam int OBC_BIT_WDOG_HW = 2;
	localparam int OBC_BIT_WDOG_HALT = 3;
	localparam int OBC_FAST_LSB = 0;
	localparam int OBC_SLOW_LSB = 2;
	localparam int OBC_BROWN_EN_BIT = 0;
	localparam int OBC_BROWN_TH_LSB = 1;

	// ****************************************************************
	// oscillator stabilisation counts per code
	// ****************************************************************
	localparam logic [12:0] OBC_WAIT_0 = 13'h0001;
	localparam logic [12:0] OBC_WAIT_1 = 13'h0010;
	localparam logic [12:0] OBC_WAIT_2 = 13'h0200;
	localparam logic [12:0] OBC_WAIT_3 = 13'h1000;

	// ****************************************************************
	// types
	// ****************************************************************
	// stored option byte image
	typedef struct packed {
		logic [7:0] readout;
		logic [7:0] boot;
		logic [7:0] dog;
		logic [7:0] osc;
		logic [7:0] brown;
		logic [7:0] ldr_hi;
		logic [7:0] ldr_lo;
	} obc_image_t;

	// one write request
	typedef struct packed {
		logic strobe;
		logic [15:0] addr;
		logic [7:0] data;
	} obc_wr_t;

	// decoded settings
	typedef struct packed {
		logic readout_protection;
		logic boot_area_en;
		logic boot_vectors_only;
		logic boot_read_prot;
		logic boot_write_prot;
		logic [7:0] boot_last_page;
		logic indep_dog_hw_activate;
		logic indep_dog_halt_stop;
		logic window_dog_hw_activate;
		logic window_dog_halt_reset;
		logic [12:0] fast_ext_osc_wait;
		logic [12:0] slow_ext_osc_wait;
		logic brownout_enable;
		logic [2:0] brownout_threshold;
	} obc_cfg_t;

	// loader sequencer states
	typedef enum logic [1:0] {
		OBC_ST_LOAD = 2'b01,
		OBC_ST_RUN = 2'b10
	} obc_state_t;

	// two-bit code to stabilisation count
	function automatic logic [12:0] obc_wait(input logic [1:0] code);
		logic [12:0] w;
		w = OBC_WAIT_0;
		unique case (code)
			2'b00: w = OBC_WAIT_0;
			2'b01: w = OBC_WAIT_1;
			2'b10: w = OBC_WAIT_2;
			2'b11: w = OBC_WAIT_3;
		endcase
		return w;
	endfunction

endpackage
`default_nettype wire

// ===== src/obc_option_byte_config.sv
// option byte store, write arbitration and settings decode
`timescale 1ns/1ps
`default_nettype none
module obc_option_byte_config
	import obc_pkg::*;
(
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// non-volatile image presented by the memory array
	input wire obc_image_t nv_image_i,
	// in-circuit writes from the single wire debug link
	input wire obc_wr_t icp_wr_i,
	// in-application writes from firmware
	input wire obc_wr_t iap_wr_i,
	// read port
	input wire logic [15:0] rd_addr_i,
	output logic [7:0] rd_data_o,
	// status and decoded settings
	output logic cfg_valid_o,
	output obc_cfg_t cfg_o
);

	// ****************************************************************
	// declarations
	// ****************************************************************
	obc_state_t state_r; // loader state
	obc_image_t image_r; // stored bytes, live copy
	logic [7:0] readout_eff_r; // protection byte in force
	logic [7:0] boot_eff_r; // boot area size in force
	logic [7:0] rd_data_r; // registered read data
	logic [7:0] rd_data_nxt; // read mux
	obc_wr_t wr_sel; // winning write request
	logic wr_is_icp; // winner came from debug link
	logic wr_go; // write accepted this cycle
	obc_cfg_t cfg_r; // decoded settings register
	obc_cfg_t cfg_nxt; // decoder output
	logic cfg_valid_r; // loaded decode is in the settings register

	// ****************************************************************
	// loader sequencer
	// ****************************************************************
	// one load cycle after reset release, then run until next reset
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			state_r <= OBC_ST_LOAD;
		end else begin
			unique case (state_r)
				OBC_ST_LOAD: state_r <= OBC_ST_RUN;
				OBC_ST_RUN: state_r <= OBC_ST_RUN;
				default: state_r <= OBC_ST_LOAD; // illegal code recovers
			endcase
		end
	end

	// ****************************************************************
	// write arbitration
	// ****************************************************************
	// debug link wins over firmware in the same cycle
	always_comb begin
		wr_is_icp = icp_wr_i.strobe;
		wr_sel = icp_wr_i.strobe ? icp_wr_i : iap_wr_i;
		// writes are ignored until the image has been loaded
		wr_go = wr_sel.strobe && (state_r == OBC_ST_RUN);
	end

	// ****************************************************************
	// stored option bytes
	// ****************************************************************
	// both paths update the stored copy of every byte
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			image_r <= '{OBC_RST_READOUT, OBC_RST_BOOT, OBC_RST_DOG,
				OBC_RST_OSC, OBC_RST_BROWN, OBC_RST_LDR, OBC_RST_LDR};
		end else if (state_r == OBC_ST_LOAD) begin
			image_r <= nv_image_i;
			image_r.dog <= nv_image_i.dog & OBC_LOW4_MASK;
			image_r.osc <= nv_image_i.osc & OBC_LOW4_MASK;
			image_r.brown <= nv_image_i.brown & OBC_LOW4_MASK;
		end else if (wr_go) begin
			unique case (wr_sel.addr)
				OBC_ADDR_READOUT: image_r.readout <= wr_sel.data;
				OBC_ADDR_BOOT: image_r.boot <= wr_sel.data;
				OBC_ADDR_DOG: image_r.dog <= wr_sel.data & OBC_LOW4_MASK;
				OBC_ADDR_OSC: image_r.osc <= wr_sel.data & OBC_LOW4_MASK;
				OBC_ADDR_BROWN: image_r.brown <= wr_sel.data & OBC_LOW4_MASK;
				OBC_ADDR_LDR_HI: image_r.ldr_hi <= wr_sel.data;
				OBC_ADDR_LDR_LO: image_r.ldr_lo <= wr_sel.data;
				default: image_r <= image_r; // reserved or unmapped
			endcase
		end
	end

	// ****************************************************************
	// protection bytes in force
	// ****************************************************************
	// firmware writes reach the store but not these copies
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			readout_eff_r <= OBC_RST_READOUT;
			boot_eff_r <= OBC_RST_BOOT;
		end else if (state_r == OBC_ST_LOAD) begin
			readout_eff_r <= nv_image_i.readout;
			boot_eff_r <= nv_image_i.boot;
		end else if (wr_go && wr_is_icp) begin
			// only in-circuit writes are taken into account
			if (wr_sel.addr == OBC_ADDR_READOUT) begin
				readout_eff_r <= wr_sel.data;
			end
			if (wr_sel.addr == OBC_ADDR_BOOT) begin
				boot_eff_r <= wr_sel.data;
			end
		end
	end

	// ****************************************************************
	// settings decode
	// ****************************************************************
	always_comb begin
		cfg_nxt = '0;
		// readout protection active unless the disable value is held
		cfg_nxt.readout_protection = (readout_eff_r != OBC_READOUT_OFF);
		// boot area size
		if (boot_eff_r == OBC_BOOT_NONE) begin
			cfg_nxt.boot_area_en = 1'b0;
		end else if (boot_eff_r == OBC_BOOT_VECT) begin
			cfg_nxt.boot_area_en = 1'b1;
			cfg_nxt.boot_vectors_only = 1'b1;
		end else if (boot_eff_r == OBC_BOOT_RWPROT) begin
			cfg_nxt.boot_area_en = 1'b1;
			cfg_nxt.boot_read_prot = 1'b1;
			cfg_nxt.boot_write_prot = 1'b1;
			cfg_nxt.boot_last_page = boot_eff_r - OBC_BOOT_STEP;
		end else begin
			cfg_nxt.boot_area_en = 1'b1;
			cfg_nxt.boot_write_prot = 1'b1;
			cfg_nxt.boot_last_page = boot_eff_r - OBC_BOOT_STEP;
		end
		// watchdog options follow the live store
		cfg_nxt.indep_dog_hw_activate = image_r.dog[OBC_BIT_IDOG_HW];
		cfg_nxt.indep_dog_halt_stop = image_r.dog[OBC_BIT_IDOG_HALT];
		cfg_nxt.window_dog_hw_activate = image_r.dog[OBC_BIT_WDOG_HW];
		cfg_nxt.window_dog_halt_reset =
			image_r.dog[OBC_BIT_WDOG_HALT];
		// oscillator stabilisation counts
		cfg_nxt.fast_ext_osc_wait =
			obc_wait(image_r.osc[OBC_FAST_LSB +: 2]);
		cfg_nxt.slow_ext_osc_wait =
			obc_wait(image_r.osc[OBC_SLOW_LSB +: 2]);
		// brownout fields are passed on undecoded
		cfg_nxt.brownout_enable = image_r.brown[OBC_BROWN_EN_BIT];
		cfg_nxt.brownout_threshold = image_r.brown[OBC_BROWN_TH_LSB +: 3];
	end

	// ****************************************************************
	// settings register
	// ****************************************************************
	// decoded values leave from flip-flops
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			cfg_r <= '0;
		end else begin
			cfg_r <= cfg_nxt;
		end
	end

	// ****************************************************************
	// read port
	// ****************************************************************
	// reserved and unmapped locations read as zero
	always_comb begin
		unique case (rd_addr_i)
			OBC_ADDR_READOUT: rd_data_nxt = image_r.readout;
			OBC_ADDR_BOOT: rd_data_nxt = image_r.boot;
			OBC_ADDR_RSVD: rd_data_nxt = OBC_RSVD_READ;
			OBC_ADDR_DOG: rd_data_nxt = image_r.dog;
			OBC_ADDR_OSC: rd_data_nxt = image_r.osc;
			OBC_ADDR_BROWN: rd_data_nxt = image_r.brown;
			OBC_ADDR_LDR_HI: rd_data_nxt = image_r.ldr_hi;
			OBC_ADDR_LDR_LO: rd_data_nxt = image_r.ldr_lo;
			default: rd_data_nxt = OBC_RSVD_READ;
		endcase
	end

	// read data register
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			rd_data_r <= OBC_RSVD_READ;
		end else begin
			rd_data_r <= rd_data_nxt;
		end
	end

	// ****************************************************************
	// settings valid flag
	// ****************************************************************
	// rises with the first registered decode of the loaded image, so a
	// consumer never latches the factory decode of the load cycle
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			cfg_valid_r <= 1'b0;
		end else begin
			cfg_valid_r <= (state_r == OBC_ST_RUN);
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign rd_data_o = rd_data_r;
	assign cfg_o = cfg_r;
	// settings valid once the decode of the loaded image is registered
	assign cfg_valid_o = cfg_valid_r;

endmodule // obc_option_byte_config
`default_nettype wire

// ===== verification/obc_checker.sv
// assertion checker for the option byte configuration block
`timescale 1ns/1ps
`default_nettype none
module obc_checker
	import obc_pkg::*;
(
	// watched ports
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire obc_image_t nv_image_i,
	input wire obc_wr_t icp_wr_i,
	input wire obc_wr_t iap_wr_i,
	input wire logic [15:0] rd_addr_i,
	input wire logic [7:0] rd_data_o,
	input wire logic cfg_valid_o,
	input wire obc_cfg_t cfg_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	// debug link write taken at this edge
	wire ic = icp_wr_i.strobe && cfg_valid_o;
	wire [15:0] a = icp_wr_i.addr;
	wire [7:0] d = icp_wr_i.data;
	wire [1:0] fc = d[1:0];
	wire [1:0] sc = d[3:2];
	// code to count: 1, 16, 512, 4096
	function automatic logic [12:0] cnt(input logic [1:0] c);
		return 13'h0001 << ((c == 2'h0) ? 0 : (c == 2'h1) ? 4 : (c == 2'h2) ? 9 : 12);
	endfunction
	property p_readout;
		ic && a == OBC_ADDR_READOUT |-> ##2
			cfg_o.readout_protection == ($past(d, 2) != 8'hAA);
	endproperty
	a_readout: assert property (p_readout)
		else $error("protection not from debug write");
	property p_iap;
		iap_wr_i.strobe && !icp_wr_i.strobe && cfg_valid_o &&
			iap_wr_i.addr == OBC_ADDR_READOUT |=> ##1 $stable(cfg_o.readout_protection);
	endproperty
	a_iap: assert property (p_iap)
		else $error("firmware changed protection");
	// firmware write of the boot area size is stored but not in force
	property p_iap_boot;
		iap_wr_i.strobe && !icp_wr_i.strobe && cfg_valid_o &&
			iap_wr_i.addr == OBC_ADDR_BOOT |=> ##1
			$stable(cfg_o.boot_last_page) && $stable(cfg_o.boot_area_en);
	endproperty
	a_iap_boot: assert property (p_iap_boot)
		else $error("firmware changed boot area");
	property p_dog;
		ic && a == OBC_ADDR_DOG |-> ##2 ($past(d, 2) & 8'h0F) ==
			{4'h0, cfg_o.window_dog_halt_reset, cfg_o.window_dog_hw_activate,
			cfg_o.indep_dog_halt_stop, cfg_o.indep_dog_hw_activate};
	endproperty
	a_dog: assert property (p_dog)
		else $error("watchdog bits wrong");
	property p_osc;
		ic && a == OBC_ADDR_OSC |-> ##2 cfg_o.fast_ext_osc_wait == cnt($past(fc, 2))
			&& cfg_o.slow_ext_osc_wait == cnt($past(sc, 2));
	endproperty
	a_osc: assert property (p_osc)
		else $error("oscillator wait wrong");
	property p_boot3;
		ic && a == OBC_ADDR_BOOT && d > 8'h02 |-> ##2 cfg_o.boot_write_prot &&
			!cfg_o.boot_read_prot &&
			cfg_o.boot_last_page == $past(d, 2) - 8'h01;
	endproperty
	a_boot3: assert property (p_boot3)
		else $error("large boot area wrong");
	property p_boot2;
		ic && a == OBC_ADDR_BOOT && d == 8'h02 |-> ##2 cfg_o.boot_read_prot &&
			cfg_o.boot_write_prot && cfg_o.boot_last_page == 8'h01;
	endproperty
	a_boot2: assert property (p_boot2)
		else $error("two page boot area wrong");
	property p_boot0;
		ic && a == OBC_ADDR_BOOT && d == 8'h00 |-> ##2 !cfg_o.boot_area_en;
	endproperty
	a_boot0: assert property (p_boot0)
		else $error("empty boot area enabled");
	property p_hold;
		(cfg_valid_o && !icp_wr_i.strobe && !iap_wr_i.strobe) [*2] |=> $stable(cfg_o);
	endproperty
	a_hold: assert property (p_hold)
		else $error("settings moved without a write");
	property p_load;
		$rose(cfg_valid_o) |->
			cfg_o.readout_protection == (nv_image_i.readout != 8'hAA);
	endproperty
	a_load: assert property (p_load)
		else $error("loaded protection wrong");
	property p_rsvd;
		rd_addr_i == OBC_ADDR_RSVD |=> rd_data_o == 8'h00;
	endproperty
	a_rsvd: assert property (p_rsvd)
		else $error("reserved byte not zero");
	c_icp: cover property (ic);
	c_tie: cover property (ic && iap_wr_i.strobe);
	c_iap: cover property (iap_wr_i.strobe && !icp_wr_i.strobe && cfg_valid_o);
endmodule // obc_checker
bind obc_option_byte_config obc_checker i_obc_checker(.clk_sys_i(clk_sys_i),
	.rst_i(rst_i), .nv_image_i(nv_image_i), .icp_wr_i(icp_wr_i),
	.iap_wr_i(iap_wr_i), .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o),
	.cfg_valid_o(cfg_valid_o), .cfg_o(cfg_o));
`default_nettype wire

// ===== verification/obc_tool_model.sv
// programming tool model writing option bytes over the debug link
`timescale 1ns/1ps
`default_nettype none
module obc_tool_model
	import obc_pkg::*;
(
	// clock
	input wire logic clk_sys_i,
	// write request toward the block
	output obc_wr_t wr_o
);
	initial wr_o = '0;
	// one byte, after lag idle cycles; released lines show inverted values
	task automatic send(input logic [15:0] a, input logic [7:0] d, input int lag);
		repeat (lag) @(posedge clk_sys_i);
		wr_o <= {1'b1, a, d};
		@(posedge clk_sys_i);
		#1;
		wr_o <= {1'b0, ~a, ~d};
	endtask
endmodule // obc_tool_model
`default_nettype wire

// ===== verification/tb_top.sv
// self-checking testbench of the option byte configuration block
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import obc_pkg::*;
;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	obc_image_t nv_image_i = {8'hAA, 8'h03, 8'h05, 8'h0E, 8'h03, 8'h12, 8'h34};
	obc_wr_t icp_wr_i;
	obc_wr_t iap_wr_i = '0;
	logic [15:0] rd_addr_i = 16'h0000;
	logic [7:0] rd_data_o;
	logic cfg_valid_o;
	obc_cfg_t cfg_o;
	int fail_count = 0;
	int n_checks = 0;
	always #10 clk_sys_i = ~clk_sys_i;
	obc_option_byte_config i_obc_option_byte_config(.clk_sys_i(clk_sys_i),
		.rst_i(rst_i), .nv_image_i(nv_image_i), .icp_wr_i(icp_wr_i),
		.iap_wr_i(iap_wr_i), .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o),
		.cfg_valid_o(cfg_valid_o), .cfg_o(cfg_o));
	obc_tool_model i_obc_tool_model(.clk_sys_i(clk_sys_i), .wr_o(icp_wr_i));
	// one comparison, counted; a mismatch prints one line
	task automatic chk(input string n, input logic [15:0] e,
		input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		rd_addr_i = a;
		tick(2);
		chk("rd_data_o", {8'h00, e}, {8'h00, rd_data_o});
	endtask
	task automatic in_application_programming(input logic [15:0] a, input logic [7:0] d);
		iap_wr_i = {1'b1, a, d};
		tick(1);
		iap_wr_i = '0;
		tick(3);
	endtask
	task automatic in_circuit_programming(input logic [15:0] a, input logic [7:0] d);
		i_obc_tool_model.send(a, d, 0);
		tick(3);
	endtask
	// code to stabilisation count: 1, 16, 512, 4096
	function automatic logic [15:0] wt(input logic [1:0] c);
		return (c == 2'h0) ? 16'h0001 : (c == 2'h1) ? 16'h0010 :
			(c == 2'h2) ? 16'h0200 : 16'h1000;
	endfunction
	// four watchdog bits packed as they sit in the byte
	function automatic logic [15:0] dogs();
		return {12'h000, cfg_o.window_dog_halt_reset,
			cfg_o.window_dog_hw_activate, cfg_o.indep_dog_halt_stop,
			cfg_o.indep_dog_hw_activate};
	endfunction
	// release reset, wait for the loader, check image and decode
	task automatic t_load();
		logic [15:0] ad[9] = '{16'h4800, 16'h4802, 16'h4807, 16'h4808,
			16'h4809, 16'h480A, 16'h480B, 16'h480C, 16'h4801};
		logic [7:0] ex[9] = '{8'hAA, 8'h03, 8'h00, 8'h05, 8'h0E, 8'h03,
			8'h12, 8'h34, 8'h00};
		rst_i = 1'b0;
		for (int i = 0; i < 10 && cfg_valid_o !== 1'b1; i++) tick(1);
		chk("cfg_valid_o", 16'h0001, {15'h0, cfg_valid_o});
		tick(2);
		chk("readout_protection", 16'h0000,
			{15'h0, cfg_o.readout_protection});
		chk("boot_last_page", 16'h0002,
			{8'h00, cfg_o.boot_last_page});
		chk("dogs", 16'h0005, dogs());
		chk("fast_wait", wt(2'h2),
			{3'h0, cfg_o.fast_ext_osc_wait});
		chk("slow_wait", wt(2'h3),
			{3'h0, cfg_o.slow_ext_osc_wait});
		chk("brownout", 16'h0003, {12'h000,
			cfg_o.brownout_threshold, cfg_o.brownout_enable});
		for (int i = 0; i < 9; i++) rd(ad[i], ex[i]);
	endtask
	// every watchdog and oscillator code, sample protection, boot and brownout codes, through the debug link
	task automatic t_icp();
		logic [7:0] bc[5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'hFF};
		in_circuit_programming(OBC_ADDR_READOUT, 8'h55);
		chk("readout_protection", 16'h0001,
			{15'h0, cfg_o.readout_protection});
		in_circuit_programming(OBC_ADDR_READOUT, 8'hAA);
		chk("readout_protection", 16'h0000,
			{15'h0, cfg_o.readout_protection});
		foreach (bc[i]) begin
			in_circuit_programming(OBC_ADDR_BOOT, bc[i]);
			chk("boot_flags",
				{12'h0, bc[i] != 0, bc[i] == 1, bc[i] == 2, bc[i] > 1},
				{12'h0, cfg_o.boot_area_en, cfg_o.boot_vectors_only,
				cfg_o.boot_read_prot,
				cfg_o.boot_write_prot});
			if (bc[i] != 0)
				chk("boot_last_page", (bc[i] == 1) ? 16'h0 : bc[i] - 1,
					{8'h00, cfg_o.boot_last_page});
		end
		for (int c = 0; c < 16; c++) begin
			in_circuit_programming(OBC_ADDR_DOG, {4'hF, c[3:0]});
			chk("dogs", c[15:0], dogs());
			rd(OBC_ADDR_DOG, {4'h0, c[3:0]});
			in_circuit_programming(OBC_ADDR_OSC, c[7:0]);
			chk("fast_wait", wt(c[1:0]),
				{3'h0, cfg_o.fast_ext_osc_wait});
			chk("slow_wait", wt(c[3:2]),
				{3'h0, cfg_o.slow_ext_osc_wait});
		end
		// brownout keeps its low nibble, loader bytes are plain storage
		in_circuit_programming(OBC_ADDR_BROWN, 8'hFF);
		rd(OBC_ADDR_BROWN, 8'h0F);
		chk("brownout", 16'h000F, {12'h000,
			cfg_o.brownout_threshold, cfg_o.brownout_enable});
		in_circuit_programming(OBC_ADDR_LDR_HI, 8'h5A);
		in_circuit_programming(OBC_ADDR_LDR_LO, 8'hC3);
		rd(OBC_ADDR_LDR_HI, 8'h5A);
		rd(OBC_ADDR_LDR_LO, 8'hC3);
		// the reserved location ignores writes and reads zero
		in_circuit_programming(OBC_ADDR_RSVD, 8'hFF);
		rd(OBC_ADDR_RSVD, 8'h00);
	endtask
	// firmware writes: protection bytes stored only, others live, tie lost
	task automatic t_iap();
		in_application_programming(OBC_ADDR_READOUT, 8'h00);
		rd(OBC_ADDR_READOUT, 8'h00);
		chk("readout_protection", 16'h0000,
			{15'h0, cfg_o.readout_protection});
		in_application_programming(OBC_ADDR_BOOT, 8'h00);
		rd(OBC_ADDR_BOOT, 8'h00);
		chk("boot_last_page", 16'h00FE,
			{8'h00, cfg_o.boot_last_page});
		in_application_programming(OBC_ADDR_DOG, 8'h0A);
		chk("dogs", 16'h000A, dogs());
		fork
			i_obc_tool_model.send(OBC_ADDR_DOG, 8'h03, 0);
			in_application_programming(OBC_ADDR_DOG, 8'h0C);
		join
		tick(2);
		chk("dogs", 16'h0003, dogs());
	endtask
	// reset in mid-run reloads the non-volatile image
	task automatic t_rst2();
		rst_i = 1'b1;
		tick(3);
		chk("cfg_valid_o", 16'h0000, {15'h0, cfg_valid_o});
		t_load();
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_sys_i);
		fail_count++;
		complete_run();
	end
	initial begin
		tick(8);
		t_load();
		t_icp();
		t_iap();
		t_rst2();
		complete_run();
	end
endmodule // tb_top
`default_nettype wire
